// ### logic/output_pll_cfg.sv
// Output PLL configuration registers: loop filter, sync gating, calibration, RF dividers.
// Assumes lock, calibration-done and feedback-detect inputs come from pins or other clocks.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "pll_cfg_defs.svh"

// Behaviour
// - Zero resistor bypass resets 0, 1 bypasses
// - Sync gated off until calibrated and locked
// - After calibration and lock, sync armed
// - Override bit ignores lock and calibration, sync always armed
// - Writing 1 starts VCO calibration
// - Second divider code bits 7:4
// - First divider code bits 3:0
// - Mode 0 holds dividers down until detect
// - Mode 1 does not hold dividers
// - Bit 1 powers down second divider
// - Bit 0 powers down first divider
// - Reserved fields read documented reset values
// - Armed sync passes to distribution control
module output_pll_cfg (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register port
  input wire logic [10:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Analog status from outside the clock domain
  input wire logic pll_locked,
  input wire logic cal_done,
  input wire logic fb_detected,
  input wire logic full_powerdown,
  // Analog controls
  output logic [6:0] loop_pole_capacitor,
  output logic zero_resistor_bypass,
  output logic vco_cal_start,
  output logic sync_armed,
  output logic [3:0] second_ratio,
  output logic [3:0] first_ratio,
  output logic second_post_divider_powerdown,
  output logic first_post_divider_powerdown
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pll_cfg_pkg::regs_type regs;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic fb_seen;
    pll_cfg_pkg::sync_state_type sstate;
    logic cal_pulse;
    logic armed;
    logic [6:0] pole_pf;
    logic [3:0] r2;
    logic [3:0] r1;
    logic pd2;
    logic pd1;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  rf_div_if second_if ();
  rf_div_if first_if ();
  logic [6:0] pole_pf;

  assign second_if.code = st_r.regs.second_code;
  assign first_if.code = st_r.regs.first_code;

  rf_ratio_decode second_dec (
    .dif(second_if.decoder)
  );
  rf_ratio_decode first_dec (
    .dif(first_if.decoder)
  );
  pole_cap_decode pole_dec (
    .code(st_r.regs.pole_code),
    .pf(pole_pf)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic locked_s;
  logic caldone_s;
  logic fbdet_s;
  logic fullpd_s;
  logic hold;

  always_comb
  begin
    st_nxt = st_r;
    // Two-flop synchronisers; stage 1 feeds only stage 2
    st_nxt.sync1 = {pll_locked, cal_done, fb_detected, full_powerdown};
    st_nxt.sync2 = st_r.sync1;
    locked_s = st_r.sync2[3];
    caldone_s = st_r.sync2[2];
    fbdet_s = st_r.sync2[1];
    fullpd_s = st_r.sync2[0];
    st_nxt.cal_pulse = 1'b0;

    if (wr)
    begin
      unique case (addr)
        `ADDR_FILTER_POLE: st_nxt.regs.pole_code = wdata[2:0];
        `ADDR_ZERO_BYPASS: st_nxt.regs.zero_bypass = wdata[`BIT_ZERO_BYPASS];
        `ADDR_SYNC_CAL:
        begin
          st_nxt.regs.lock_override = wdata[`BIT_LOCK_OVERRIDE];
          st_nxt.regs.manual_cal = wdata[`BIT_MANUAL_CAL];
          // Rising edge only, so a repeated 1 does not restart calibration
          st_nxt.cal_pulse = wdata[`BIT_MANUAL_CAL] & ~st_r.regs.manual_cal;
        end
        `ADDR_RF_RATIO:
        begin
          st_nxt.regs.second_code = wdata[7:4];
          st_nxt.regs.first_code = wdata[3:0];
        end
        `ADDR_RF_POWER:
        begin
          st_nxt.regs.startup_mode = wdata[`BIT_STARTUP_MODE];
          st_nxt.regs.pd_second = wdata[`BIT_PD_SECOND];
          st_nxt.regs.pd_first = wdata[`BIT_PD_FIRST];
        end
        default: ;
      endcase
    end

    // Read data valid the cycle after the strobe; unmapped reads zero
    st_nxt.regs.rdata = 8'h00;
    if (rd)
    begin
      unique case (addr)
        `ADDR_FILTER_POLE: st_nxt.regs.rdata = {5'h00, st_r.regs.pole_code};
        `ADDR_ZERO_BYPASS: st_nxt.regs.rdata = {7'h00, st_r.regs.zero_bypass};
        `ADDR_SYNC_CAL: st_nxt.regs.rdata = {`RST_SYNC_TOP, st_r.regs.lock_override,
                                             2'h0, st_r.regs.manual_cal};
        `ADDR_SPARE: st_nxt.regs.rdata = 8'h00;
        `ADDR_RF_RATIO: st_nxt.regs.rdata = {st_r.regs.second_code, st_r.regs.first_code};
        `ADDR_RF_POWER: st_nxt.regs.rdata = {3'h0, st_r.regs.startup_mode, 2'h0,
                                             st_r.regs.pd_second, st_r.regs.pd_first};
        default: st_nxt.regs.rdata = 8'h00;
      endcase
    end

    // A fresh calibration drops the arm; the old done flag is stale until it falls
    unique case (st_r.sstate)
      pll_cfg_pkg::sync_wait_type_idle:
      begin
        if (st_r.cal_pulse)
          st_nxt.sstate = pll_cfg_pkg::sync_wait_type_wait;
        else if (caldone_s && locked_s)
          st_nxt.sstate = pll_cfg_pkg::sync_wait_type_armed;
      end
      pll_cfg_pkg::sync_wait_type_wait:
      begin
        // Limitation: a calibration too short to drop done at this rate keeps sync unarmed
        if (!caldone_s)
          st_nxt.sstate = pll_cfg_pkg::sync_wait_type_idle;
      end
      pll_cfg_pkg::sync_wait_type_armed:
      begin
        if (st_r.cal_pulse)
          st_nxt.sstate = pll_cfg_pkg::sync_wait_type_wait;
        else if (!locked_s || !caldone_s)
          st_nxt.sstate = pll_cfg_pkg::sync_wait_type_idle;
      end
      default: st_nxt.sstate = pll_cfg_pkg::sync_wait_type_idle;
    endcase

    // Arm passes control to the distribution sync register
    st_nxt.armed = st_r.regs.lock_override |
                   (st_nxt.sstate == pll_cfg_pkg::sync_wait_type_armed);

    // Feedback detect tracked per power-up; full power-down clears it
    if (fullpd_s)
      st_nxt.fb_seen = 1'b0;
    else if (fbdet_s)
      st_nxt.fb_seen = 1'b1;
    hold = ~st_r.regs.startup_mode & ~st_r.fb_seen;
    st_nxt.pd2 = st_r.regs.pd_second | hold;
    st_nxt.pd1 = st_r.regs.pd_first | hold;

    st_nxt.pole_pf = pole_pf;
    st_nxt.r2 = second_if.ratio;
    st_nxt.r1 = first_if.ratio;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      st_r.regs.pole_code <= `RST_POLE_CODE;
      st_r.regs.zero_bypass <= `RST_ZERO_BYPASS;
      st_r.regs.second_code <= `RST_RF_CODE;
      st_r.regs.first_code <= `RST_RF_CODE;
      st_r.regs.startup_mode <= `RST_STARTUP_MODE;
      st_r.regs.pd_second <= `RST_PD_SECOND;
      st_r.regs.pd_first <= `RST_PD_FIRST;
      st_r.sstate <= pll_cfg_pkg::sync_wait_type_idle;
      st_r.pole_pf <= `RST_POLE_PF;
      st_r.r2 <= `RST_RF_RATIO;
      st_r.r1 <= `RST_RF_RATIO;
      st_r.pd2 <= `RST_PD_HELD;
      st_r.pd1 <= `RST_PD_HELD;
    end
    else
      st_r <= st_nxt;
  end

  assign rdata = st_r.regs.rdata;
  assign loop_pole_capacitor = st_r.pole_pf;
  assign zero_resistor_bypass = st_r.regs.zero_bypass;
  assign vco_cal_start = st_r.cal_pulse;
  assign sync_armed = st_r.armed;
  assign second_ratio = st_r.r2;
  assign first_ratio = st_r.r1;
  assign second_post_divider_powerdown = st_r.pd2;
  assign first_post_divider_powerdown = st_r.pd1;

endmodule : output_pll_cfg

// ### logic/pll_cfg_defs.svh
// Offsets, field positions and reset values of the output PLL configuration block.
// Assumes byte-wide registers reached by an 11-bit word address.
`ifndef PLL_CFG_DEFS_SVH
`define PLL_CFG_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_FILTER_POLE 11'h403
`define ADDR_ZERO_BYPASS 11'h404
`define ADDR_SYNC_CAL 11'h405
`define ADDR_SPARE 11'h406
`define ADDR_RF_RATIO 11'h407
`define ADDR_RF_POWER 11'h408

// ****************************************
// Reset values
// ****************************************
`define RST_POLE_CODE 3'h7
`define RST_ZERO_BYPASS 1'h0
`define RST_SYNC_TOP 4'h2
`define RST_RF_CODE 4'h4
`define RST_STARTUP_MODE 1'h0
`define RST_PD_SECOND 1'h1
`define RST_PD_FIRST 1'h0
// Output copies: both dividers come out of reset held down
`define RST_POLE_PF 7'h78
`define RST_RF_RATIO 4'h6
`define RST_PD_HELD 1'h1

// ****************************************
// Field positions
// ****************************************
`define BIT_ZERO_BYPASS 0
`define BIT_LOCK_OVERRIDE 3
`define BIT_MANUAL_CAL 0
`define BIT_STARTUP_MODE 4
`define BIT_PD_SECOND 1
`define BIT_PD_FIRST 0

// ****************************************
// Divider ratio encoding
// ****************************************
`define RF_MIN_RATIO 4'h3
`define RF_MAX_CODE 4'h9
`define RF_MAX_RATIO 4'hb
`define RF_TWIN_CODE 4'h1
`define RF_CODE_STEP 4'h2

`endif

// ### logic/pll_cfg_pkg.sv
// Types shared by the output PLL configuration block.
// Assumes the constants header is compiled alongside.
package pll_cfg_pkg;

  typedef enum logic [1:0] {
    sync_wait_type_idle = 2'b00,
    sync_wait_type_wait = 2'b01,
    sync_wait_type_armed = 2'b10
  } sync_state_type;

  typedef struct packed {
    logic [2:0] pole_code;
    logic zero_bypass;
    logic lock_override;
    logic manual_cal;
    logic [3:0] second_code;
    logic [3:0] first_code;
    logic startup_mode;
    logic pd_second;
    logic pd_first;
    logic [7:0] rdata;
  } regs_type;

endpackage : pll_cfg_pkg

// ### logic/rf_div_if.sv
// Carrier between the top and the divider ratio decoder.
// Assumes one decoder per divider.
`timescale 1ns/1ns
interface rf_div_if;
  logic [3:0] code;
  logic [3:0] ratio;
  modport decoder (input code, output ratio);
  modport user (output code, input ratio);
endinterface : rf_div_if

// ### logic/rf_ratio_decode.sv
// Decodes a 4-bit divider code into its division ratio.
// Assumes codes above the top code clamp to the top ratio.
`timescale 1ns/1ns
`include "pll_cfg_defs.svh"
module rf_ratio_decode (
  rf_div_if.decoder dif
);

  // Codes 0 and 1 both give the least ratio; above the top code, clamp
  always_comb
  begin
    if (dif.code <= `RF_TWIN_CODE)
      dif.ratio = `RF_MIN_RATIO;
    else if (dif.code > `RF_MAX_CODE)
      dif.ratio = `RF_MAX_RATIO;
    else
      dif.ratio = 4'(dif.code + `RF_CODE_STEP);
  end

endmodule : rf_ratio_decode

// ### logic/pole_cap_decode.sv
// Decodes the loop pole capacitor code into picofarads.
// Assumes a pure combinational lookup.
`timescale 1ns/1ns
module pole_cap_decode (
  // Code in
  input wire logic [2:0] code,
  // Capacitance out
  output logic [6:0] pf
);

  always_comb
  begin
    unique case (code)
      3'h0: pf = 7'h00;
      3'h1: pf = 7'h14;
      3'h2: pf = 7'h50;
      3'h3: pf = 7'h64;
      3'h4: pf = 7'h14;
      3'h5: pf = 7'h28;
      3'h6: pf = 7'h64;
      3'h7: pf = 7'h78;
    endcase
  end

endmodule : pole_cap_decode

// ### dv/output_pll_cfg_checker.sv
// Assertions on the ports of the output PLL configuration block.
// Assumes it is bound to output_pll_cfg with one clock domain.
`timescale 1ns/1ns
module output_pll_cfg_checker (
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [10:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Analog controls
  input wire logic [6:0] loop_pole_capacitor,
  input wire logic vco_cal_start,
  input wire logic sync_armed,
  input wire logic [3:0] second_ratio,
  input wire logic [3:0] first_ratio
);
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  cal_cause_a:
    assert property (vco_cal_start |-> $past(wr) && $past(addr) == 11'h405 && $past(wdata[0]))
    else $error("calibration pulse without a write of one");
  cal_single_a:
    assert property (vco_cal_start |=> !vco_cal_start) else $error("calibration pulse too long");
  spare_zero_a:
    assert property (rd && addr == 11'h406 |=> rdata == 8'h00) else $error("spare not zero");
  sync_top_a:
    assert property (rd && addr == 11'h405 |=> rdata[7:4] == 4'h2 && rdata[2:1] == 2'b00)
    else $error("sync register reserved bits wrong");
  bypass_top_a:
    assert property (rd && addr == 11'h404 |=> rdata[7:1] == 7'h00)
    else $error("bypass register reserved bits wrong");
  ratio_first_a:
    assert property (first_ratio >= 4'h3 && first_ratio <= 4'hb) else $error("first ratio range");
  ratio_second_a:
    assert property (second_ratio >= 4'h3 && second_ratio <= 4'hb) else $error("second ratio range");
  ratio_top_a:
    assert property (wr && addr == 11'h407 && wdata[3:0] == 4'h9 |-> ##[1:2] first_ratio == 4'hb)
    else $error("top code not eleven");
  override_arm_a:
    assert property (wr && addr == 11'h405 && wdata[3] && !wdata[0] |-> ##[1:2] sync_armed)
    else $error("override did not arm sync");
  pole_max_a:
    assert property (loop_pole_capacitor <= 7'h78) else $error("pole capacitor above maximum");
endmodule : output_pll_cfg_checker

bind output_pll_cfg output_pll_cfg_checker u_chk (.mclk(mclk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .loop_pole_capacitor(loop_pole_capacitor),
  .vco_cal_start(vco_cal_start), .sync_armed(sync_armed), .second_ratio(second_ratio),
  .first_ratio(first_ratio));

// ### dv/output_pll_cfg_tb.sv
// Self-checking bench for the output PLL configuration block.
// Assumes design, package and header are compiled first; drives the status pins itself.
`timescale 1ns/1ns
module output_pll_cfg_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pll_locked = 1'b0;
  logic cal_done = 1'b0;
  logic fb_detected = 1'b0;
  logic full_powerdown = 1'b0;
  logic [7:0] rdata;
  logic [6:0] pole;
  logic bypass;
  logic cal_start;
  logic armed;
  logic [3:0] ratio2;
  logic [3:0] ratio1;
  logic pd2;
  logic pd1;
  int fail_count = 0;
  int total_checks = 0;
  localparam logic [7:0] pf_tbl [8] = '{8'h00, 8'h14, 8'h50, 8'h64, 8'h14, 8'h28, 8'h64, 8'h78};
  localparam logic [7:0] rst_tbl [6] = '{8'h07, 8'h00, 8'h20, 8'h00, 8'h44, 8'h02};
  always #50 mclk = ~mclk;
  output_pll_cfg u_dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pll_locked(pll_locked), .cal_done(cal_done),
    .fb_detected(fb_detected), .full_powerdown(full_powerdown), .loop_pole_capacitor(pole),
    .zero_resistor_bypass(bypass), .vco_cal_start(cal_start), .sync_armed(armed),
    .second_ratio(ratio2), .first_ratio(ratio1), .second_post_divider_powerdown(pd2),
    .first_post_divider_powerdown(pd1));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task wr_reg(input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task rd_chk(input logic [10:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk
  // Status inputs pass two flops, so controls settle a few edges late
  task wait_ctl(input logic [2:0] exp);
    int i;
    // Look just after an edge so the registered controls have settled
    #1;
    for (i = 0; i < 20 && {armed, pd2, pd1} !== exp; i++)
    begin
      @(posedge mclk);
      #1;
    end
    check({5'h00, armed, pd2, pd1}, {5'h00, exp});
    if (i == 20)
      give_verdict;
  endtask : wait_ctl
  // ****************
  // Stimulus
  // ****************
  initial
  begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    check({1'b0, pole}, 8'h78);
    check({4'h0, bypass, armed, pd2, pd1}, 8'h03);
    check({ratio2, ratio1}, 8'h66);
    for (int c = 0; c < 6; c++)
      rd_chk(11'h403 + 11'(c), rst_tbl[c]);
    wr_reg(11'h406, 8'hff);
    rd_chk(11'h406, 8'h00);
    wr_reg(11'h400, 8'hff);
    rd_chk(11'h400, 8'h00);
    wr_reg(11'h404, 8'hff);
    rd_chk(11'h404, 8'h01);
    check({7'h00, bypass}, 8'h01);
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(11'h403, 8'(c));
      rd_chk(11'h403, 8'(c));
      check({1'b0, pole}, pf_tbl[c]);
    end
    for (int c = 0; c < 10; c++)
    begin
      wr_reg(11'h407, {4'(c), 4'(9 - c)});
      @(posedge mclk);
      #1;
      check({ratio2, ratio1}, {4'(c < 2 ? 3 : c + 2), 4'(c > 7 ? 3 : 11 - c)});
    end
    // Codes above the top code clamp to the top ratio
    wr_reg(11'h407, 8'hfa);
    @(posedge mclk);
    #1;
    check({ratio2, ratio1}, 8'hbb);
    // Second write of one must not restart calibration
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(11'h405, {7'h00, c != 2});
      check({7'h00, cal_start}, {7'h00, c == 0 || c == 3});
    end
    wr_reg(11'h405, 8'h00);
    @(posedge mclk);
    cal_done <= 1'b1;
    repeat (8) @(posedge mclk);
    wait_ctl(3'b011);
    @(posedge mclk);
    pll_locked <= 1'b1;
    wait_ctl(3'b111);
    // New calibration: stale done must not re-arm before it falls and rises
    wr_reg(11'h405, 8'h01);
    @(posedge mclk);
    cal_done <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check({7'h00, armed}, 8'h00);
    @(posedge mclk);
    cal_done <= 1'b1;
    wait_ctl(3'b111);
    @(posedge mclk);
    pll_locked <= 1'b0;
    wait_ctl(3'b011);
    wr_reg(11'h405, 8'h08);
    wait_ctl(3'b111);
    wr_reg(11'h405, 8'h00);
    wait_ctl(3'b011);
    wr_reg(11'h408, 8'h00);
    repeat (8) @(posedge mclk);
    wait_ctl(3'b011);
    @(posedge mclk);
    fb_detected <= 1'b1;
    wait_ctl(3'b000);
    wr_reg(11'h408, 8'h02);
    wait_ctl(3'b010);
    wr_reg(11'h408, 8'h01);
    wait_ctl(3'b001);
    @(posedge mclk);
    full_powerdown <= 1'b1;
    fb_detected <= 1'b0;
    repeat (8) @(posedge mclk);
    full_powerdown <= 1'b0;
    wr_reg(11'h408, 8'h00);
    repeat (8) @(posedge mclk);
    wait_ctl(3'b011);
    wr_reg(11'h408, 8'h10);
    wait_ctl(3'b000);
    rd_chk(11'h408, 8'h10);
    give_verdict;
  end
endmodule : output_pll_cfg_tb
